//--- rtl/sgd_go_ctrl.sv
// Divider-five control, GO command sequencer and AHB-Lite register slave.
// What this block does
// - Enable bit 15 stops or runs divider five
// - Divider five divides by ratio code plus one
// - Reserved bits read zero, writes ignored
// - Writing go bit one starts GO; zero clears
// - Go bit stays one; a one-write while idle starts GO again
// - Busy status reads one during ratio change
// - Unaligned changed clock switches right after GO
// - Aligned clock switches on common phase boundary
// - New ratio value sets changed flag; GO uses flags
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module sgd_go_ctrl
  import sgd_pkg::*;
#(
  parameter int ALIGN_CYCLES = ALIGN_PERIOD
)
(
  input  wire logic        CLK_SYS,   // System clock, 125 MHz.
  input  wire logic        NRST,      // Asynchronous reset, active low.
  input  wire logic        HSEL,      // Slave select.
  input  wire logic [31:0] HADDR,     // Byte address.
  input  wire logic [1:0]  HTRANS,    // Transfer type.
  input  wire logic        HWRITE,    // Write when high.
  input  wire logic [2:0]  HSIZE,     // Transfer size, word only.
  input  wire logic [31:0] HWDATA,    // Write data.
  input  wire logic        HREADY,    // Bus ready.
  output logic      [31:0] HRDATA,    // Read data.
  output logic             HREADYOUT, // Slave ready, always high.
  output logic             HRESP,     // Response, always OKAY.
  output logic             DIV5_TICK, // Divider-five output pulse.
  output logic             GO_BUSY    // GO operation in progress.
);

  localparam int REF_W = $clog2(ALIGN_CYCLES);

  sgd_div_ctl_type     div5_reg;
  logic [ALIGN_W-1:0]  align_reg;
  logic                go_bit_reg;
  logic                changed5_reg;
  logic                busy_reg;
  sgd_go_state_type    state_reg;
  sgd_go_state_type    state_next;
  logic                wr_pend_reg;
  logic [31:0]         wr_addr_reg;
  logic [REF_W-1:0]    ref_cnt_reg;
  logic                ref_tick;
  logic                addr_phase;
  logic                wr_en;
  logic                go_start;
  logic                div_load;
  logic                div_restart;
  logic                div_tick;
  logic [31:0]         rd_value;

  // Read image of a register; anything outside the map reads as zero.
  function automatic logic [31:0] read_image(input logic [31:0] addr);
    logic [31:0] v;
    v = 32'h00000000;
    unique case (addr)
      GO_COMMAND_ADDR:    v[GO_BIT_POS] = go_bit_reg;
      CTRL_STATUS_ADDR:   v[BUSY_BIT_POS] = busy_reg;
      ALIGN_CTRL_ADDR:    v[ALIGN_LSB +: ALIGN_W] = align_reg;
      RATIO_CHANGED_ADDR: v[DIV5_CHANGED_POS] = changed5_reg;
      DIV_FIVE_ADDR:
      begin
        v[DIV_EN_POS] = div5_reg.enable;
        v[RATIO_LSB +: RATIO_W] = div5_reg.ratio;
      end
      default:            v = 32'h00000000;
    endcase
    return v;
  endfunction : read_image

  // Bus handshake terms; the slave never inserts wait states.
  assign addr_phase = HSEL && HTRANS[1] && HREADY;
  assign wr_en      = wr_pend_reg && HREADY;
  assign go_start   = wr_en && (wr_addr_reg == GO_COMMAND_ADDR)
                      && HWDATA[GO_BIT_POS];

  // A process, not an assign, so that a register change alone re-evaluates
  // the image while the address stands still during polling.
  always_comb
  begin
    rd_value = read_image(HADDR);
  end

  // Ready and response are constant once out of reset.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      HREADYOUT <= 1'b1;
      HRESP     <= HRESP_OKAY;
    end
    else
    begin
      HREADYOUT <= 1'b1;
      HRESP     <= HRESP_OKAY;
    end
  end

  // Write data arrives one cycle after its address, so the address is held.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h00000000;
    end
    else if (HREADY)
    begin
      wr_pend_reg <= addr_phase && HWRITE;
      wr_addr_reg <= HADDR;
    end
  end

  // Read data is sampled in the address phase so it stands from a flop.
  // A read right behind a write to the same register sees the old value.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      HRDATA <= 32'h00000000;
    end
    else if (addr_phase && !HWRITE)
    begin
      HRDATA <= rd_value;
    end
  end

  // Divider-five control; only bit 15 and bits 4:0 are stored.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      div5_reg.enable <= DIV_EN_RESET;
      div5_reg.ratio  <= RATIO_RESET;
    end
    else if (wr_en && (wr_addr_reg == DIV_FIVE_ADDR))
    begin
      div5_reg.enable <= HWDATA[DIV_EN_POS];
      div5_reg.ratio  <= HWDATA[RATIO_LSB +: RATIO_W];
    end
  end

  // Align selects; software is expected to keep the default.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      align_reg <= ALIGN_RESET;
    end
    else if (wr_en && (wr_addr_reg == ALIGN_CTRL_ADDR))
    begin
      align_reg <= HWDATA[ALIGN_LSB +: ALIGN_W];
    end
  end

  // The go bit reads back what was last written to it.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      go_bit_reg <= 1'b0;
    end
    else if (wr_en && (wr_addr_reg == GO_COMMAND_ADDR))
    begin
      go_bit_reg <= HWDATA[GO_BIT_POS];
    end
  end

  // Changed flag: a new ratio sets it, the end of GO clears it.
  // Set wins, so a ratio write in the finishing cycle is not lost.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      changed5_reg <= 1'b0;
    end
    else if (wr_en && (wr_addr_reg == DIV_FIVE_ADDR)
             && (HWDATA[RATIO_LSB +: RATIO_W] != div5_reg.ratio))
    begin
      changed5_reg <= 1'b1;
    end
    else if (state_reg == GO_FINISH)
    begin
      changed5_reg <= 1'b0;
    end
  end

  // Free-running phase reference shared by every aligned clock.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      ref_cnt_reg <= '0;
    end
    else if (ref_cnt_reg == REF_W'(ALIGN_CYCLES - 1))
    begin
      ref_cnt_reg <= '0;
    end
    else
    begin
      ref_cnt_reg <= ref_cnt_reg + 1'b1;
    end
  end

  assign ref_tick = (ref_cnt_reg == '0);

  // GO sequencer. A go write while busy is ignored; software polls first.
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      GO_IDLE:
      begin
        if (go_start)
        begin
          state_next = GO_SWITCH;
        end
      end
      GO_SWITCH:
      begin
        if (changed5_reg && align_reg[DIV5_SLOT])
        begin
          state_next = GO_ALIGN;
        end
        else
        begin
          state_next = GO_FINISH;
        end
      end
      GO_ALIGN:
      begin
        if (ref_tick)
        begin
          state_next = GO_FINISH;
        end
      end
      GO_FINISH:
      begin
        state_next = GO_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      state_reg <= GO_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Busy rises with the command and falls once the new ratio runs.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      busy_reg <= 1'b0;
    end
    else if (state_reg == GO_IDLE && go_start)
    begin
      busy_reg <= 1'b1;
    end
    else if (state_reg == GO_FINISH)
    begin
      busy_reg <= 1'b0;
    end
  end

  // Ratio hand-over: unaligned clocks switch at once, aligned ones on
  // the common boundary with their phase restarted there.
  assign div_load = (state_reg == GO_SWITCH && changed5_reg
                     && !align_reg[DIV5_SLOT])
                    || (state_reg == GO_ALIGN && ref_tick);
  assign div_restart = (state_reg == GO_ALIGN) && ref_tick;

  sgd_ratio_div #(
    .RW        (RATIO_W)
  ) u_div5 (
    .clk       (CLK_SYS),
    .nrst      (NRST),
    .run       (div5_reg.enable),
    .load      (div_load),
    .restart   (div_restart),
    .new_ratio (div5_reg.ratio),
    .tick      (div_tick)
  );

  // Outputs from flops; the tick is already registered inside the divider.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      GO_BUSY <= 1'b0;
    end
    else
    begin
      GO_BUSY <= busy_reg && (state_reg != GO_FINISH);
    end
  end

  assign DIV5_TICK = div_tick;

endmodule : sgd_go_ctrl
`default_nettype wire

//--- inc/sgd_pkg.sv
// Package with register map, field layout and types of the divider-five GO control.
package sgd_pkg;

  // Byte addresses of the registers on the AHB-Lite bus.
  localparam logic [31:0] GO_COMMAND_ADDR    = 32'h029a0138;
  localparam logic [31:0] CTRL_STATUS_ADDR   = 32'h029a013c;
  localparam logic [31:0] ALIGN_CTRL_ADDR    = 32'h029a0140;
  localparam logic [31:0] RATIO_CHANGED_ADDR = 32'h029a0144;
  localparam logic [31:0] DIV_FIVE_ADDR      = 32'h029a0164;

  // Field positions.
  localparam int GO_BIT_POS       = 0;
  localparam int BUSY_BIT_POS     = 0;
  localparam int DIV_EN_POS       = 15;
  localparam int RATIO_LSB        = 0;
  localparam int RATIO_W          = 5;
  localparam int ALIGN_LSB        = 3;
  localparam int ALIGN_W          = 2;
  localparam int DIV5_SLOT        = 1;
  localparam int DIV4_CHANGED_POS = 3;
  localparam int DIV5_CHANGED_POS = 4;

  // Reset values.
  localparam logic [ALIGN_W-1:0] ALIGN_RESET = 2'h3;
  localparam logic               DIV_EN_RESET = 1'h0;
  localparam logic [RATIO_W-1:0] RATIO_RESET  = 5'h00;

  // Common phase boundary of all ratios 1 to 8, in system clock cycles.
  localparam int ALIGN_PERIOD = 840;

  // AHB-Lite encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // Divider-five control fields as they travel together.
  typedef struct packed {
    logic               enable;
    logic [RATIO_W-1:0] ratio;
  } sgd_div_ctl_type;

  // GO sequencer states, Gray coded along IDLE, SWITCH, ALIGN, FINISH.
  typedef enum logic [1:0] {
    GO_IDLE   = 2'b00,
    GO_SWITCH = 2'b01,
    GO_ALIGN  = 2'b11,
    GO_FINISH = 2'b10
  } sgd_go_state_type;

endpackage : sgd_pkg

//--- rtl/sgd_ratio_div.sv
// Programmable divide-by-N tick generator for one derived clock.
`timescale 1ns/1ps
`default_nettype none
module sgd_ratio_div
  import sgd_pkg::*;
#(
  parameter int RW = RATIO_W
)
(
  input  wire logic          clk,       // System clock.
  input  wire logic          nrst,      // Asynchronous reset, active low.
  input  wire logic          run,       // Divider enabled.
  input  wire logic          load,      // Take new_ratio as the active ratio.
  input  wire logic          restart,   // Restart the phase at count zero.
  input  wire logic [RW-1:0] new_ratio, // Ratio code, divide by code plus one.
  output logic               tick       // One-cycle pulse per output period.
);

  logic [RW-1:0] ratio_reg;
  logic [RW-1:0] count_reg;
  logic [RW-1:0] count_next;
  logic [RW-1:0] limit;

  // A fresh ratio takes effect on the very cycle it is loaded.
  assign limit = load ? new_ratio : ratio_reg;

  // Count wraps at the limit; a shrinking ratio wraps at once, never late.
  always_comb
  begin
    if (!run || restart)
    begin
      count_next = '0;
    end
    else if (count_reg >= limit)
    begin
      count_next = '0;
    end
    else
    begin
      count_next = count_reg + 1'b1;
    end
  end

  // Active ratio.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ratio_reg <= RATIO_RESET;
    end
    else if (load)
    begin
      ratio_reg <= new_ratio;
    end
  end

  // Phase counter.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count_reg <= '0;
    end
    else
    begin
      count_reg <= count_next;
    end
  end

  // With the divider stopped no tick is produced at all.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tick <= 1'b0;
    end
    else
    begin
      tick <= run && (count_next == '0);
    end
  end

endmodule : sgd_ratio_div
`default_nettype wire

//--- testbench/sgd_go_ctrl_checker.sv
// Concurrent checks on the ports of the divider-five GO control.
`timescale 1ns/1ps
`default_nettype none
module sgd_go_checker
  import sgd_pkg::*;
#(
  parameter int ALIGN_CYCLES = ALIGN_PERIOD
)
(
  input wire logic        CLK_SYS,   // System clock.
  input wire logic        NRST,      // Reset, active low.
  input wire logic        HSEL,      // Slave select.
  input wire logic [31:0] HADDR,     // Byte address.
  input wire logic [1:0]  HTRANS,    // Transfer type.
  input wire logic        HWRITE,    // Write when high.
  input wire logic [31:0] HWDATA,    // Write data.
  input wire logic        HREADY,    // Bus ready.
  input wire logic [31:0] HRDATA,    // Read data.
  input wire logic        DIV5_TICK, // Divider-five pulse.
  input wire logic        GO_BUSY    // GO in progress.
);
  localparam int MAXB = ALIGN_CYCLES + 4;
  logic        take;
  logic        go_req;
  logic        wr_reg;
  logic [31:0] adr_reg;
  logic        en_reg;
  logic        al_reg;
  logic        go_reg;

  // Reserved positions of each address; unmapped places read all zero.
  function automatic logic [31:0] rsv(input logic [31:0] a);
    case (a)
      GO_COMMAND_ADDR:    rsv = 32'hffff_fffe;
      CTRL_STATUS_ADDR:   rsv = 32'hffff_fffe;
      ALIGN_CTRL_ADDR:    rsv = 32'hffff_ffe7;
      RATIO_CHANGED_ADDR: rsv = 32'hffff_ffef;
      DIV_FIVE_ADDR:      rsv = 32'hffff_7fe0;
      default:            rsv = 32'hffff_ffff;
    endcase
  endfunction : rsv

  // A go request is the data phase of a one-write to the command word.
  assign take = HSEL && HTRANS[1] && HREADY;
  assign go_req = wr_reg && adr_reg == GO_COMMAND_ADDR && HWDATA[GO_BIT_POS];

  // Shadow of the write fields that the checks below depend on.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      wr_reg  <= 1'b0;
      adr_reg <= 32'h0;
      en_reg  <= DIV_EN_RESET;
      al_reg  <= ALIGN_RESET[1];
      go_reg  <= 1'b0;
    end
    else
    begin
      wr_reg  <= take && HWRITE;
      adr_reg <= HADDR;
      if (wr_reg && adr_reg == DIV_FIVE_ADDR)
        en_reg <= HWDATA[DIV_EN_POS];
      if (wr_reg && adr_reg == ALIGN_CTRL_ADDR)
        al_reg <= HWDATA[ALIGN_LSB+1];
      if (wr_reg && adr_reg == GO_COMMAND_ADDR)
        go_reg <= HWDATA[GO_BIT_POS];
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  sequence s_busy_up;
    ##2 GO_BUSY;
  endsequence
  sequence s_quick_end;
    ##[1:2] !GO_BUSY;
  endsequence

  a_go_starts: assert property (go_req && !GO_BUSY |-> s_busy_up)
    else $error("GO write did not raise busy");
  a_busy_cause: assert property ($rose(GO_BUSY) |-> $past(go_req, 2))
    else $error("Busy rose without a GO write");
  a_busy_bounded: assert property ($rose(GO_BUSY) |-> ##[1:MAXB] !GO_BUSY)
    else $error("GO operation did not finish in time");
  a_unaligned_fast: assert property (go_req && !GO_BUSY && !al_reg |-> s_busy_up ##0 s_quick_end)
    else $error("Unaligned GO took too long");
  a_status_busy: assert property (take && !HWRITE && HADDR == CTRL_STATUS_ADDR && GO_BUSY |=> HRDATA[BUSY_BIT_POS])
    else $error("Status read zero while busy");
  a_reserved_zero: assert property (take && !HWRITE |=> (HRDATA & rsv($past(HADDR))) == 32'h0)
    else $error("Reserved read bits not zero");
  a_go_bit_reads: assert property (take && !HWRITE && HADDR == GO_COMMAND_ADDR |=> HRDATA[GO_BIT_POS] == $past(go_reg))
    else $error("Go bit read wrong value");
  a_off_no_tick: assert property (!en_reg && !$past(en_reg) && !$past(en_reg, 2) |-> !DIV5_TICK)
    else $error("Tick while divider disabled");
endmodule : sgd_go_checker

bind sgd_go_ctrl sgd_go_checker #(.ALIGN_CYCLES(ALIGN_CYCLES)) i_chk (
  .CLK_SYS(CLK_SYS), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HRDATA(HRDATA), .DIV5_TICK(DIV5_TICK), .GO_BUSY(GO_BUSY));
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the divider-five GO control.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sgd_pkg::*;
  localparam int ALC = 8;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        tick;
  logic        busy;
  int          bad_count = 0;
  int          checked = 0;
  int          cyc = 0;
  int          en_m = 0;
  int          rat_m = 0;
  int          act_m = 0;
  int          flag_m = 0;
  int          al_m = 3;
  int          go_m = 0;
  logic [31:0] adrs [$] = {GO_COMMAND_ADDR, CTRL_STATUS_ADDR,
    ALIGN_CTRL_ADDR, RATIO_CHANGED_ADDR, DIV_FIVE_ADDR, 32'h029a0148};

  sgd_go_ctrl #(.ALIGN_CYCLES(ALC)) i_dut (
    .CLK_SYS(clk_sys), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .DIV5_TICK(tick), .GO_BUSY(busy));

  // Free-running 125 MHz clock and a hang guard.
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One AHB-Lite single transfer; entered just after a rising edge.
  task automatic bus(input logic [31:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask : wr

  // Register contents as the model holds them; status idle.
  function automatic logic [31:0] exp_of(input logic [31:0] a);
    case (a)
      GO_COMMAND_ADDR:    exp_of = 32'(go_m);
      ALIGN_CTRL_ADDR:    exp_of = 32'(al_m) << 3;
      RATIO_CHANGED_ADDR: exp_of = 32'(flag_m) << 4;
      DIV_FIVE_ADDR:      exp_of = 32'(en_m * 32768 + rat_m);
      default:            exp_of = 32'h0;
    endcase
  endfunction : exp_of

  task automatic rd_all;
    logic [31:0] r;
    foreach (adrs[i])
    begin
      bus(adrs[i], 1'b0, 32'h0, r);
      chk(r, exp_of(adrs[i]));
      chk(32'(hresp), 32'(HRESP_OKAY));
    end
  endtask : rd_all

  // Start GO, then poll status until idle as software must.
  task automatic go_run;
    logic [31:0] r;
    int          n;
    bus(CTRL_STATUS_ADDR, 1'b0, 32'h0, r);
    chk(r, 32'h0);
    wr(GO_COMMAND_ADDR, 32'hffff_ffff);
    go_m = 1;
    bus(CTRL_STATUS_ADDR, 1'b0, 32'h0, r);
    chk(r, 32'h1);
    n = 0;
    while (r[0] !== 1'b0 && n < ALC + 20)
    begin
      bus(CTRL_STATUS_ADDR, 1'b0, 32'h0, r);
      n++;
    end
    chk(r, 32'h0);
    if (flag_m != 0)
      act_m = rat_m;
    flag_m = 0;
    rd_all();
  endtask : go_run

  // Cycles between two successive divider ticks.
  task automatic period(output int p);
    p = 0;
    @(posedge clk_sys);
    while (tick !== 1'b1) @(posedge clk_sys);
    do
    begin
      @(posedge clk_sys);
      p++;
    end while (tick !== 1'b1);
  endtask : period

  initial
  begin
    int v;
    int a;
    int p;
    int n;
    v = $urandom(32'h1bd2);
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd_all();
    // Random ratios, each applied by GO with alignment on or off at random.
    repeat (8)
    begin
      v = $urandom % 8;
      a = $urandom % 2;
      wr(ALIGN_CTRL_ADDR, (a != 0) ? 32'hffff_ffff : 32'hffff_ffef);
      al_m = (a != 0) ? 3 : 1;
      wr(DIV_FIVE_ADDR, 32'hffff_ffe0 | 32'(v));
      en_m = 1;
      if (v != rat_m)
        flag_m = 1;
      rat_m = v;
      rd_all();
      period(p);
      chk(32'(p), 32'(act_m + 1));
      go_run();
      period(p);
      chk(32'(p), 32'(act_m + 1));
    end
    // Back to the default align selects that software should keep.
    wr(ALIGN_CTRL_ADDR, 32'h0000_0018);
    al_m = 3;
    // Disabled divider stays silent.
    wr(DIV_FIVE_ADDR, 32'h0000_0002);
    en_m = 0;
    if (rat_m != 2)
      flag_m = 1;
    rat_m = 2;
    repeat (3) @(posedge clk_sys);
    n = 0;
    repeat (40)
    begin
      @(posedge clk_sys);
      if (tick !== 1'b0)
        n++;
    end
    chk(32'(n), 32'h0);
    wr(GO_COMMAND_ADDR, 32'h0);
    go_m = 0;
    rd_all();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
